/* File: rtl/adc_readout_pkg.sv */
`default_nettype none
package adc_readout_pkg;

  localparam int RESULT_WIDTH = 12;
  localparam int CLOCKS_PER_SAMPLE = 16;
  localparam int FIFO_DEPTH = 16;
  localparam int CONV_COUNT_WIDTH = 5;
  localparam logic [RESULT_WIDTH-1:0] RESULT_RESET = 12'h000;
  localparam logic [CONV_COUNT_WIDTH-1:0] CONV_COUNT_RESET = 5'h00;

  typedef enum logic [1:0] {
    CONV_IDLE,
    CONV_RUN,
    CONV_PUSH
  } conv_state_e;

  // One finished conversion: the pair index and both side results
  typedef struct packed {
    logic pair;
    logic [RESULT_WIDTH-1:0] side_a;
    logic [RESULT_WIDTH-1:0] side_b;
  } conv_record_s;

  // Host-side strobes of the parallel port
  typedef struct packed {
    logic conversion_trigger;
    logic channel_pick;
    logic select_n;
    logic read_n;
  } host_pins_s;

endpackage
`default_nettype wire

/* File: rtl/record_fifo.sv */
`timescale 1ns/1ps
`default_nettype none
module record_fifo #(
  parameter int WIDTH = 25,
  parameter int DEPTH = 16
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
  logic [CW-1:0] count_q, count_d;
  logic push, pop;

  assign in_ready = (count_q != CW'(DEPTH));
  assign out_valid = (count_q != '0);
  assign out_data = mem[rd_q];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb begin
    wr_d = wr_q;
    rd_d = rd_q;
    count_d = count_q;
    if (push) begin
      wr_d = (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
    end
    if (pop) begin
      rd_d = (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
    end
    if (push && !pop) begin
      count_d = count_q + 1'b1;
    end else if (pop && !push) begin
      count_d = count_q - 1'b1;
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      wr_q <= '0;
      rd_q <= '0;
      count_q <= '0;
    end else begin
      wr_q <= wr_d;
      rd_q <= rd_d;
      count_q <= count_d;
    end
  end

  // Storage carries no reset; only the pointers and the count define validity
  always_ff @(posedge clock) begin
    if (push) begin
      mem[wr_q] <= in_data;
    end
  end

endmodule
`default_nettype wire

/* File: rtl/dual_adc_parallel_readout.sv */
// Contract
// - Busy high while a conversion runs and until its record enters the buffer
// - Conversion paced by external clock, sixteen per sample
// - Trigger falling edge latches channel_pick pair choice
// - First read edge gives A, second gives B
// - channel_pick during read picks input 0 or 1
`timescale 1ns/1ps
`default_nettype none
module dual_adc_parallel_readout
  import adc_readout_pkg::*;
#(
  parameter int WIDTH = RESULT_WIDTH,
  parameter int CONV_CLOCKS = CLOCKS_PER_SAMPLE,
  parameter int DEPTH = FIFO_DEPTH
) (
  input wire logic clock,
  input wire logic reset,
  input wire host_pins_s host_pins,
  input wire logic conv_clock,
  input wire logic [WIDTH-1:0] sample_a,
  input wire logic [WIDTH-1:0] sample_b,
  output logic conv_pair,
  output logic busy,
  output logic [WIDTH-1:0] result_bus_out,
  output logic result_bus_oe,
  output logic fifo_full
);

  // ************************************************************
  // Edge detection on host pins and the conversion clock
  // ************************************************************
  logic trig_prev_q, trig_prev_d;
  logic read_prev_q, read_prev_d;
  logic cclk_prev_q, cclk_prev_d;
  logic trig_fall, read_fall, cclk_rise, selected;

  assign selected = !host_pins.select_n;
  assign trig_fall = trig_prev_q && !host_pins.conversion_trigger;
  assign read_fall = read_prev_q && !host_pins.read_n;
  assign cclk_rise = !cclk_prev_q && conv_clock;

  always_comb begin
    trig_prev_d = host_pins.conversion_trigger;
    read_prev_d = host_pins.read_n;
    cclk_prev_d = conv_clock;
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      trig_prev_q <= 1'b1;
      read_prev_q <= 1'b1;
      cclk_prev_q <= 1'b0;
    end else begin
      trig_prev_q <= trig_prev_d;
      read_prev_q <= read_prev_d;
      cclk_prev_q <= cclk_prev_d;
    end
  end

  // ************************************************************
  // Conversion sequencer
  // ************************************************************
  conv_state_e state_q, state_d;
  logic [CONV_COUNT_WIDTH-1:0] count_q, count_d;
  logic pair_q, pair_d;
  conv_record_s record_q, record_d;
  logic push_valid, push_ready;

  assign push_valid = (state_q == CONV_PUSH);

  always_comb begin
    state_d = state_q;
    count_d = count_q;
    pair_d = pair_q;
    record_d = record_q;
    case (state_q)
      CONV_IDLE: begin
        if (trig_fall) begin
          pair_d = host_pins.channel_pick;
          count_d = CONV_COUNT_RESET;
          state_d = CONV_RUN;
        end
      end
      CONV_RUN: begin
        // Only edges of the external clock advance the conversion
        if (cclk_rise) begin
          if (count_q == CONV_COUNT_WIDTH'(CONV_CLOCKS - 1)) begin
            record_d.pair = pair_q;
            record_d.side_a = sample_a;
            record_d.side_b = sample_b;
            state_d = CONV_PUSH;
          end else begin
            count_d = count_q + 1'b1;
          end
        end
      end
      CONV_PUSH: begin
        // A full buffer holds the sequencer here, so busy stretches
        if (push_ready) begin
          state_d = CONV_IDLE;
        end
      end
      default: begin
        state_d = CONV_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      state_q <= CONV_IDLE;
      count_q <= CONV_COUNT_RESET;
      pair_q <= 1'b0;
      record_q <= '0;
    end else begin
      state_q <= state_d;
      count_q <= count_d;
      pair_q <= pair_d;
      record_q <= record_d;
    end
  end

  assign busy = (state_q != CONV_IDLE);
  assign conv_pair = pair_q;

  // ************************************************************
  // Result buffer
  // ************************************************************
  conv_record_s pop_data;
  logic pop_valid, pop_ready;
  logic read_mid_q, read_mid_d;

  // Draining pauses between the A and B reads so a pair stays coherent
  assign pop_ready = !read_mid_q;
  assign fifo_full = !push_ready;

  record_fifo #(
    .WIDTH($bits(conv_record_s)),
    .DEPTH(DEPTH)
  ) u_fifo (
    .clock(clock),
    .reset(reset),
    .in_data(record_q),
    .in_valid(push_valid),
    .in_ready(push_ready),
    .out_data(pop_data),
    .out_valid(pop_valid),
    .out_ready(pop_ready)
  );

  // ************************************************************
  // Result registers, indexed by input number
  // ************************************************************
  logic [WIDTH-1:0] res_a_q [2];
  logic [WIDTH-1:0] res_a_d [2];
  logic [WIDTH-1:0] res_b_q [2];
  logic [WIDTH-1:0] res_b_d [2];

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_input
      always_comb begin
        res_a_d[gi] = res_a_q[gi];
        res_b_d[gi] = res_b_q[gi];
        if (pop_valid && pop_ready && (pop_data.pair == 1'(gi))) begin
          res_a_d[gi] = pop_data.side_a;
          res_b_d[gi] = pop_data.side_b;
        end
      end

      always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
          res_a_q[gi] <= RESULT_RESET;
          res_b_q[gi] <= RESULT_RESET;
        end else begin
          res_a_q[gi] <= res_a_d[gi];
          res_b_q[gi] <= res_b_d[gi];
        end
      end
    end
  endgenerate

  // ************************************************************
  // Parallel read port
  // ************************************************************
  logic [WIDTH-1:0] out_q, out_d;
  logic oe_q, oe_d;

  always_comb begin
    read_mid_d = read_mid_q;
    out_d = out_q;
    oe_d = selected && !host_pins.read_n;
    if (!selected) begin
      read_mid_d = 1'b0;
    end else if (read_fall) begin
      if (!read_mid_q) begin
        out_d = res_a_q[host_pins.channel_pick];
        read_mid_d = 1'b1;
      end else begin
        out_d = res_b_q[host_pins.channel_pick];
        read_mid_d = 1'b0;
      end
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      read_mid_q <= 1'b0;
      out_q <= RESULT_RESET;
      oe_q <= 1'b0;
    end else begin
      read_mid_q <= read_mid_d;
      out_q <= out_d;
      oe_q <= oe_d;
    end
  end

  assign result_bus_out = out_q;
  assign result_bus_oe = oe_q;

endmodule
`default_nettype wire

/* File: sim/readout_properties.sv */
`timescale 1ns/1ps
`default_nettype none
module readout_properties
  import adc_readout_pkg::*;
#(
  parameter int WIDTH = RESULT_WIDTH,
  parameter int CONV_CLOCKS = CLOCKS_PER_SAMPLE
) (
  input wire logic clock,
  input wire logic reset,
  input wire host_pins_s host_pins,
  input wire logic conv_clock,
  input wire logic conv_pair,
  input wire logic busy,
  input wire logic [WIDTH-1:0] result_bus_out,
  input wire logic result_bus_oe
);
  // ****
  // Checks
  // ****
  logic cc_q;
  logic [7:0] rises_q;
  // Counts only while busy is seen, so one rise of slack on each side
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      cc_q <= 1'b0;
      rises_q <= 8'h00;
    end else begin
      cc_q <= conv_clock;
      rises_q <= !busy ? 8'h00 : rises_q + 8'(conv_clock && !cc_q);
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  property p_start;
    $fell(host_pins.conversion_trigger) && !busy |=> busy;
  endproperty
  a_start: assert property (p_start) else $error("busy did not start");
  property p_idle;
    !busy && !$fell(host_pins.conversion_trigger) |=> !busy;
  endproperty
  a_idle: assert property (p_idle) else $error("busy without trigger");
  property p_len;
    $fell(busy) |-> rises_q >= CONV_CLOCKS - 1 && rises_q <= CONV_CLOCKS + 1;
  endproperty
  a_len: assert property (p_len) else $error("conversion length wrong");
  property p_pair;
    $rose(busy) |-> conv_pair == $past(host_pins.channel_pick);
  endproperty
  a_pair: assert property (p_pair) else $error("pair not latched");
  property p_pair_hold;
    busy && $past(busy) |-> $stable(conv_pair);
  endproperty
  a_pair_hold: assert property (p_pair_hold) else $error("pair moved");
  property p_hold;
    !($fell(host_pins.read_n) && !host_pins.select_n) |=> $stable(result_bus_out);
  endproperty
  a_hold: assert property (p_hold) else $error("data moved without read");
  property p_oe;
    result_bus_oe |-> $past(!host_pins.select_n && !host_pins.read_n);
  endproperty
  a_oe: assert property (p_oe) else $error("bus driven unselected");
  property p_release;
    host_pins.select_n |=> !result_bus_oe;
  endproperty
  a_release: assert property (p_release) else $error("bus not released");
  c_conv: cover property ($fell(busy));
  c_pair1: cover property ($rose(busy) && conv_pair);
  c_read: cover property ($rose(result_bus_oe));
endmodule
bind dual_adc_parallel_readout readout_properties #(.WIDTH(WIDTH), .CONV_CLOCKS(CONV_CLOCKS)) u_readout_properties (
  .clock(clock), .reset(reset), .host_pins(host_pins), .conv_clock(conv_clock), .conv_pair(conv_pair),
  .busy(busy), .result_bus_out(result_bus_out), .result_bus_oe(result_bus_oe));
`default_nettype wire

/* File: sim/front_end_model.sv */
`timescale 1ns/1ps
`default_nettype none
module front_end_model (
  input wire logic clock,
  input wire logic reset,
  output logic conv_clock
);
  // ****
  // Conversion clock source
  // ****
  // Half the system rate keeps conversions short
  always_ff @(posedge clock or posedge reset) begin
    if (reset) conv_clock <= 1'b0;
    else conv_clock <= !conv_clock;
  end
endmodule
`default_nettype wire

/* File: sim/dual_adc_parallel_readout_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module dual_adc_parallel_readout_bench
  import adc_readout_pkg::*;
();
  // ****
  // Bench
  // ****
  logic clock = 1'b0;
  logic reset = 1'b1;
  host_pins_s hp = '{1'b1, 1'b0, 1'b1, 1'b1};
  logic [11:0] sa = 12'h000;
  logic [11:0] sb = 12'h000;
  logic [11:0] ea [2] = '{12'h000, 12'h000};
  logic [11:0] eb [2] = '{12'h000, 12'h000};
  logic [11:0] dout;
  logic conv_clock, conv_pair, busy, oe, full;
  int n_errors = 0;
  int n_compared = 0;
  always #10 clock = ~clock;
  front_end_model u_front_end_model (.clock(clock), .reset(reset), .conv_clock(conv_clock));
  // Runs with the documented sixteen conversion clocks per sample
  dual_adc_parallel_readout u_dual_adc_parallel_readout (.clock(clock), .reset(reset),
    .host_pins(hp), .conv_clock(conv_clock), .sample_a(sa), .sample_b(sb), .conv_pair(conv_pair),
    .busy(busy), .result_bus_out(dout), .result_bus_oe(oe), .fifo_full(full));
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic give_verdict();
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk_flag(input logic got, input logic exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t flag got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic convert(input logic p);
    int k;
    hp.channel_pick = p;
    hp.conversion_trigger = 1'b0;
    tick(1);
    hp.conversion_trigger = 1'b1;
    hp.channel_pick = 1'($urandom);
    tick(1);
    chk_flag(busy, 1'b1);
    chk_flag(conv_pair, p);
    // A fall while busy must be ignored, even with the other pair picked
    hp.channel_pick = !p;
    hp.conversion_trigger = 1'b0;
    tick(1);
    hp.conversion_trigger = 1'b1;
    for (k = 0; k < 100 && busy !== 1'b0; k++) tick(1);
    chk_flag(busy, 1'b0);
    chk_flag(conv_pair, p);
    ea[p] = sa;
    eb[p] = sb;
    tick(4);
  endtask
  task automatic rd(input logic p, input logic [11:0] exp);
    hp.select_n = 1'b0;
    hp.read_n = 1'b0;
    hp.channel_pick = p;
    tick(2);
    chk(dout, exp);
    chk_flag(oe, 1'b1);
    hp.read_n = 1'b1;
    tick(1);
  endtask
  initial begin
    int i;
    int r;
    logic [11:0] ob;
    void'($urandom(32'h2DEBB604));
    tick(3);
    reset = 1'b0;
    for (i = 0; i < 12; i++) begin
      r = $urandom;
      sa = (i == 0) ? 12'hFFF : 12'($urandom);
      sb = (i == 0) ? 12'h000 : 12'($urandom);
      convert(r[3]);
      rd(r[0], ea[r[0]]);
      if (i % 3 == 0) begin
        hp.select_n = 1'b1;
        tick(1);
        hp.read_n = 1'b0;
        tick(2);
        chk_flag(oe, 1'b0);
        hp.read_n = 1'b1;
        tick(1);
        rd(r[1], ea[r[1]]);
      end
      rd(r[2], eb[r[2]]);
      hp.select_n = 1'b1;
      tick(2);
      chk_flag(oe, 1'b0);
      $display("test %0d done", i);
    end
    // Parking between the A and B reads stops draining, so sixteen records queue up
    rd(1'b0, ea[0]);
    ob = eb[0];
    for (i = 0; i < 16; i++) begin
      sa = 12'($urandom);
      sb = 12'($urandom);
      convert(i[0]);
    end
    chk_flag(full, 1'b1);
    rd(1'b0, ob);
    tick(20);
    chk_flag(full, 1'b0);
    rd(1'b0, ea[0]);
    rd(1'b0, eb[0]);
    rd(1'b1, ea[1]);
    rd(1'b1, eb[1]);
    $display("test fill done");
    give_verdict();
  end
  initial begin
    // Roughly 1200 cycles are expected; ten thousand leave ample margin
    #200000;
    n_errors++;
    give_verdict();
  end
endmodule
`default_nettype wire
